// ---- hdl/mpl_consts.svh ----
// offsets, field positions, reset values and timing of the phy management poller
`ifndef MPL_CONSTS_SVH
`define MPL_CONSTS_SVH
`define MPL_OFF_CTRL 8'h00
`define MPL_OFF_ALIVE 8'h04
`define MPL_OFF_LINK 8'h08
`define MPL_OFF_SC_RAW 8'h0C
`define MPL_OFF_SC_MSK 8'h10
`define MPL_OFF_OD_RAW 8'h14
`define MPL_OFF_OD_MSK 8'h18
`define MPL_OFF_OD_MSET 8'h1C
`define MPL_OFF_OD_MCLR 8'h20
`define MPL_OFF_OP0 8'h24
`define MPL_OFF_OP1 8'h28
`define MPL_OFF_WATCH 8'h2C
`define MPL_CTRL_PRE 16
`define MPL_CTRL_ENABLE 30
`define MPL_CTRL_BUSY 31
`define MPL_OP_LAUNCH 31
`define MPL_OP_WRITE 30
`define MPL_OP_ACK 29
`define MPL_OP_REG_LSB 21
`define MPL_OP_PHY_LSB 16
`define MPL_WS_IRQ_EN 6
`define MPL_WS_LINK 7
`define MPL_STATUS_REG 5'h01
`define MPL_STATUS_LINK 2
`define MPL_START 2'h1
`define MPL_OPC_READ 2'h2
`define MPL_OPC_WRITE 2'h1
`define MPL_TA_WRITE 2'h2
`define MPL_TA_READ 2'h3
`define MPL_DATA_IDLE 16'hFFFF
`define MPL_PREAMBLE 32'hFFFFFFFF
`define MPL_IDX_FULL 6'h3F
`define MPL_IDX_SHORT 6'h1F
`define MPL_IDX_LAST 6'h00
`define MPL_BIT_TA1 6'h11
`define MPL_BIT_TA2 6'h10
`define MPL_CLK_KHZ 200000
`define MPL_MDC_MAX_KHZ 2500
`define MPL_MDC_TYP_KHZ 1000
`define MPL_DIV_RESET (`MPL_CLK_KHZ / (2 * `MPL_MDC_TYP_KHZ) - 1)
`define MPL_DIV_MIN ((`MPL_CLK_KHZ + 2 * `MPL_MDC_MAX_KHZ - 1) / (2 * `MPL_MDC_MAX_KHZ) - 1)
`endif

// ---- hdl/mpl_pkg.sv ----
// types of the phy management poller
package mpl_pkg;
   typedef enum logic [1:0]
   {
      ST_OFF = 2'b00,
      ST_PICK = 2'b01,
      ST_BUSY = 2'b11
   } mpl_state_e;
   typedef enum logic [1:0]
   {
      SRC_POLL = 2'b00,
      SRC_OP0 = 2'b01,
      SRC_OP1 = 2'b10
   } mpl_src_e;
   typedef enum logic
   {
      SER_IDLE = 1'b0,
      SER_RUN = 1'b1
   } mpl_ser_e;
   typedef struct packed
   {
      logic launch;
      logic wr;
      logic ack;
      logic [4:0] regad;
      logic [4:0] phy;
      logic [15:0] data;
   } mpl_op_s;
   typedef struct packed
   {
      mpl_state_e st;
      mpl_src_e src;
      logic rr_last;
      logic enable;
      logic pre_en;
      logic [15:0] div;
      logic [31:0] alive;
      logic [31:0] link;
      logic sc_raw;
      logic [1:0] od_raw;
      logic [1:0] od_mask;
      mpl_op_s [1:0] op;
      logic [4:0] watch_num;
      logic watch_ien;
      logic watch_link;
      logic [4:0] poll_addr;
      logic start;
      logic f_wr;
      logic [4:0] f_phy;
      logic [4:0] f_reg;
      logic [15:0] f_wdata;
      logic wait_req;
      logic [31:0] rdata;
      logic irq;
   } mpl_top_s;
   typedef struct packed
   {
      mpl_ser_e st;
      logic [15:0] cnt;
      logic mdc;
      logic mout;
      logic oe;
      logic wr;
      logic [63:0] sh;
      logic [5:0] cur;
      logic sync1;
      logic sync2;
      logic ack;
      logic [15:0] rdata;
      logic done;
   } mpl_ser_s;
endpackage

// ---- hdl/mpl_frame_if.sv ----
// carrier between the poll scheduler and the serial frame engine
`timescale 1ns/1ps
interface mpl_frame_if;
   logic start;
   logic wr;
   logic [4:0] phy;
   logic [4:0] regad;
   logic [15:0] wdata;
   logic pre_en;
   logic [15:0] divisor;
   logic mdio_in;
   logic done;
   logic ack;
   logic [15:0] rdata;
   logic mdc;
   logic mdio_out;
   logic mdio_oe;
   modport eng (output start, wr, phy, regad, wdata, pre_en, divisor, mdio_in,
      input done, ack, rdata, mdc, mdio_out, mdio_oe);
   modport ser (input start, wr, phy, regad, wdata, pre_en, divisor, mdio_in,
      output done, ack, rdata, mdc, mdio_out, mdio_oe);
endinterface

// ---- hdl/mpl_serial.sv ----
// serial frame engine: clock divider, bit shifter and turnaround sampling
`timescale 1ns/1ps
`include "mpl_consts.svh"

module mpl_serial
(
   input logic clock_i,
   input logic rst_i,
   mpl_frame_if.ser f
);
   mpl_pkg::mpl_ser_s s;
   mpl_pkg::mpl_ser_s n;
   logic tick;
   logic [31:0] frame;

   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (rst_i);

   ////////////////////////////////////////////////////////////////////////////////
   // frame word; read data lanes stay high since the pin is released there
   assign frame = {`MPL_START, f.wr ? `MPL_OPC_WRITE : `MPL_OPC_READ, f.phy, f.regad,
      f.wr ? `MPL_TA_WRITE : `MPL_TA_READ, f.wr ? f.wdata : `MPL_DATA_IDLE};

   // one bit per two half periods of divisor+1 clocks each
   always_comb
   begin
      n = s;
      n.done = 1'b0;
      n.sync1 = f.mdio_in;
      n.sync2 = s.sync1;
      tick = (s.cnt == f.divisor);
      case (s.st)
         mpl_pkg::SER_IDLE:
         begin
            n.mdc = 1'b0;
            n.oe = 1'b0;
            n.cnt = 16'h0000;
            if (f.start)
            begin
               n.sh = f.pre_en ? {`MPL_PREAMBLE, frame} : {frame, `MPL_PREAMBLE};
               n.cur = f.pre_en ? `MPL_IDX_FULL : `MPL_IDX_SHORT;
               n.mout = n.sh[63];
               n.sh = {n.sh[62:0], 1'b0};
               n.oe = 1'b1;
               n.wr = f.wr;
               n.ack = 1'b0;
               n.st = mpl_pkg::SER_RUN;
            end
         end
         mpl_pkg::SER_RUN:
         begin
            n.cnt = tick ? 16'h0000 : 16'(s.cnt + 16'h0001);
            if (tick && !s.mdc)
            begin
               // rising edge: the phy drove the line during the low half
               n.mdc = 1'b1;
               if (!s.wr && s.cur == `MPL_BIT_TA2)
                  n.ack = ~s.sync2;
               if (!s.wr && s.cur < `MPL_BIT_TA2)
                  n.rdata = {s.rdata[14:0], s.sync2};
            end
            else if (tick)
            begin
               n.mdc = 1'b0;
               if (s.cur == `MPL_IDX_LAST)
               begin
                  n.st = mpl_pkg::SER_IDLE;
                  n.oe = 1'b0;
                  n.done = 1'b1;
               end
               else
               begin
                  n.cur = 6'(s.cur - 6'h01);
                  n.mout = s.sh[63];
                  n.sh = {s.sh[62:0], 1'b0};
                  n.oe = s.wr || (n.cur > `MPL_BIT_TA1);
               end
            end
         end
         default: n.st = mpl_pkg::SER_IDLE;
      endcase
   end

   // idle line is pulled high, so the synchroniser starts high
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         s <= '0;
         s.sync1 <= 1'b1;
         s.sync2 <= 1'b1;
      end
      else
         s <= n;
   end

   assign f.mdc = s.mdc;
   assign f.mdio_out = s.mout;
   assign f.mdio_oe = s.oe;
   assign f.done = s.done;
   assign f.ack = s.ack;
   assign f.rdata = s.rdata;

   ////////////////////////////////////////////////////////////////////////////////
   chk_frame_length: assert property (f.start && s.st == mpl_pkg::SER_IDLE |=>
      s.cur == ($past(f.pre_en) ? `MPL_IDX_FULL : `MPL_IDX_SHORT))
      else $error("frame length does not follow preamble selection");
   chk_clock_half: assert property (s.st == mpl_pkg::SER_RUN && tick |=> $changed(s.mdc))
      else $error("management clock did not toggle on divider terminal count");
   chk_read_release: assert property (s.st == mpl_pkg::SER_RUN && !s.wr &&
      s.cur <= `MPL_BIT_TA1 |-> !s.oe)
      else $error("data pin driven during read turnaround or data");
endmodule

// ---- hdl/mpl_phy_poller.sv ----
// poller top: avalon slave, address poll, watched phy and two user operations
`timescale 1ns/1ps
`include "mpl_consts.svh"

////////////////////////////////////////////////////////////////////////////////
// Function
// - poll all 32 addresses reading status register
// - two-wire bus: clock out, bidirectional data
// - clock divided down by software divisor
// - idle, no bus activity until enabled
// - preamble sent unless software deselects it
// - responder bit set if answered, else cleared
// - carrier bit set only if answered and linked
// - user reads also update responder bit
// - watched address from watched-phy number field
// - watched link change sets raw/masked when enabled
// - launch flag starts encoded read or write
// - completion clears launch, sets its done bit
// - masked done follows raw when enabled, interrupts
// - two pending operations served round robin
// - acknowledge flag reports read success
// - read data stored; ack not after launch clear
module mpl_phy_poller
(
   input logic clock_i,
   input logic rst_i,
   input logic [7:0] avs_address_i,
   input logic avs_read_i,
   input logic avs_write_i,
   input logic [31:0] avs_writedata_i,
   input logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   output logic irq_o,
   output logic management_clock_pin_o,
   input logic mgmt_data_i,
   output logic mgmt_data_o,
   output logic mgmt_data_oe_o
);
   mpl_pkg::mpl_top_s s;
   mpl_pkg::mpl_top_s n;
   logic [31:0] be;
   logic [31:0] wd;
   logic [31:0] cw;
   logic [31:0] ww;
   logic [31:0] m;
   logic acc;
   logic take;
   logic pick1;
   logic ui;
   logic poll_link;

   mpl_frame_if fi ();

   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (rst_i);

   // register word of a user operation
   function automatic logic [31:0] op_word(input mpl_pkg::mpl_op_s o);
      op_word = {o.launch, o.wr, o.ack, 3'h0, o.regad, o.phy, o.data};
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // bus decode, register writes, then scheduler; hardware sets come last so they win
   always_comb
   begin
      n = s;
      n.start = 1'b0;
      be = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
         {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
      wd = avs_writedata_i & be;
      acc = (avs_read_i || avs_write_i) && s.wait_req;
      take = avs_write_i && !s.wait_req;
      pick1 = s.op[1].launch && (!s.op[0].launch || !s.rr_last);
      ui = (s.src == mpl_pkg::SRC_OP1);
      poll_link = fi.ack && fi.rdata[`MPL_STATUS_LINK];
      m = 32'h0000_0000;
      cw = 32'h0000_0000;
      cw[15:0] = s.div;
      cw[`MPL_CTRL_PRE] = s.pre_en;
      cw[`MPL_CTRL_ENABLE] = s.enable;
      cw[`MPL_CTRL_BUSY] = (s.st == mpl_pkg::ST_BUSY);
      ww = 32'h0000_0000;
      ww[4:0] = s.watch_num;
      ww[`MPL_WS_IRQ_EN] = s.watch_ien;
      ww[`MPL_WS_LINK] = s.watch_link;

      // answer one cycle after the request is seen; read data is a snapshot
      n.wait_req = !acc;
      if (acc)
      begin
         case (avs_address_i)
            `MPL_OFF_CTRL: n.rdata = cw;
            `MPL_OFF_ALIVE: n.rdata = s.alive;
            `MPL_OFF_LINK: n.rdata = s.link;
            `MPL_OFF_SC_RAW: n.rdata = {31'h0, s.sc_raw};
            `MPL_OFF_SC_MSK: n.rdata = {31'h0, s.sc_raw && s.watch_ien};
            `MPL_OFF_OD_RAW: n.rdata = {30'h0, s.od_raw};
            `MPL_OFF_OD_MSK: n.rdata = {30'h0, s.od_raw & s.od_mask};
            `MPL_OFF_OD_MSET: n.rdata = {30'h0, s.od_mask};
            `MPL_OFF_OD_MCLR: n.rdata = {30'h0, s.od_mask};
            `MPL_OFF_OP0: n.rdata = op_word(s.op[0]);
            `MPL_OFF_OP1: n.rdata = op_word(s.op[1]);
            `MPL_OFF_WATCH: n.rdata = ww;
            default: n.rdata = 32'h0000_0000;
         endcase
      end

      // writes land at the edge where waitrequest is seen low
      if (take)
      begin
         case (avs_address_i)
            `MPL_OFF_CTRL:
            begin
               m = (cw & ~be) | wd;
               n.div = m[15:0];
               n.pre_en = m[`MPL_CTRL_PRE];
               n.enable = m[`MPL_CTRL_ENABLE];
            end
            `MPL_OFF_SC_RAW: n.sc_raw = s.sc_raw & ~wd[0];
            `MPL_OFF_OD_RAW: n.od_raw = s.od_raw & ~wd[1:0];
            `MPL_OFF_OD_MSET: n.od_mask = s.od_mask | wd[1:0];
            `MPL_OFF_OD_MCLR: n.od_mask = s.od_mask & ~wd[1:0];
            `MPL_OFF_WATCH:
            begin
               m = (ww & ~be) | wd;
               n.watch_num = m[4:0];
               n.watch_ien = m[`MPL_WS_IRQ_EN];
            end
            default: n.enable = s.enable;
         endcase
         // an operation in flight is protected: its register ignores writes
         for (int i = 0; i < 2; i++)
         begin
            if (avs_address_i == ((i == 0) ? `MPL_OFF_OP0 : `MPL_OFF_OP1) &&
               !s.op[i].launch)
            begin
               m = (op_word(s.op[i]) & ~be) | wd;
               n.op[i].launch = m[`MPL_OP_LAUNCH];
               n.op[i].wr = m[`MPL_OP_WRITE];
               n.op[i].ack = 1'b0;
               n.op[i].regad = m[`MPL_OP_REG_LSB +: 5];
               n.op[i].phy = m[`MPL_OP_PHY_LSB +: 5];
               n.op[i].data = m[15:0];
            end
         end
      end

      // scheduler: one frame at a time, user work ahead of polling
      case (s.st)
         mpl_pkg::ST_OFF:
         begin
            if (s.enable)
               n.st = mpl_pkg::ST_PICK;
         end
         mpl_pkg::ST_PICK:
         begin
            if (!s.enable)
               n.st = mpl_pkg::ST_OFF;
            else
            begin
               if (s.op[0].launch || s.op[1].launch)
               begin
                  n.src = pick1 ? mpl_pkg::SRC_OP1 : mpl_pkg::SRC_OP0;
                  n.rr_last = pick1;
                  n.f_wr = s.op[pick1].wr;
                  n.f_phy = s.op[pick1].phy;
                  n.f_reg = s.op[pick1].regad;
                  n.f_wdata = s.op[pick1].data;
               end
               else
               begin
                  n.src = mpl_pkg::SRC_POLL;
                  n.f_wr = 1'b0;
                  n.f_phy = s.poll_addr;
                  n.f_reg = `MPL_STATUS_REG;
                  n.f_wdata = 16'h0000;
               end
               n.start = 1'b1;
               n.st = mpl_pkg::ST_BUSY;
            end
         end
         mpl_pkg::ST_BUSY:
         begin
            if (fi.done)
            begin
               n.st = mpl_pkg::ST_PICK;
               if (s.src == mpl_pkg::SRC_POLL)
               begin
                  n.alive[s.poll_addr] = fi.ack;
                  n.link[s.poll_addr] = poll_link;
                  n.poll_addr = 5'(s.poll_addr + 5'h01);
                  if (s.poll_addr == s.watch_num)
                  begin
                     n.watch_link = poll_link;
                     if (poll_link != s.watch_link && s.watch_ien)
                        n.sc_raw = 1'b1;
                  end
               end
               else
               begin
                  n.op[ui].launch = 1'b0;
                  n.od_raw[ui] = 1'b1;
                  if (!s.op[ui].wr)
                  begin
                     n.op[ui].data = fi.rdata;
                     n.op[ui].ack = fi.ack;
                     n.alive[s.op[ui].phy] = fi.ack;
                  end
               end
            end
         end
         default: n.st = mpl_pkg::ST_OFF;
      endcase

      // single request line toward the processor
      n.irq = ((n.od_raw & n.od_mask) != 2'b00) || (n.sc_raw && n.watch_ien);
   end

   // reset leaves the engine off with preamble on and the typical divisor
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         s <= '0;
         s.div <= 16'(`MPL_DIV_RESET);
         s.pre_en <= 1'b1;
         s.wait_req <= 1'b1;
      end
      else
         s <= n;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // frame engine and pins
   assign fi.start = s.start;
   assign fi.wr = s.f_wr;
   assign fi.phy = s.f_phy;
   assign fi.regad = s.f_reg;
   assign fi.wdata = s.f_wdata;
   assign fi.pre_en = s.pre_en;
   assign fi.divisor = s.div;
   assign fi.mdio_in = mgmt_data_i;

   mpl_serial u_serial
   (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .f(fi)
   );

   assign management_clock_pin_o = fi.mdc;
   assign mgmt_data_o = fi.mdio_out;
   assign mgmt_data_oe_o = fi.mdio_oe;
   assign avs_readdata_o = s.rdata;
   assign avs_waitrequest_o = s.wait_req;
   assign irq_o = s.irq;

   ////////////////////////////////////////////////////////////////////////////////
   sequence poll_end;
      fi.done && s.st == mpl_pkg::ST_BUSY && s.src == mpl_pkg::SRC_POLL;
   endsequence
   sequence watch_flip;
      poll_end and (s.poll_addr == s.watch_num && s.watch_ien && poll_link != s.watch_link);
   endsequence
   sequence op0_end;
      fi.done && s.st == mpl_pkg::ST_BUSY && s.src == mpl_pkg::SRC_OP0;
   endsequence

   chk_off_quiet: assert property (!s.enable && s.st == mpl_pkg::ST_OFF |=>
      s.st == mpl_pkg::ST_OFF && !s.start && !fi.mdio_oe)
      else $error("bus activity while disabled");
   chk_poll_maps: assert property (poll_end |=>
      s.alive[$past(s.poll_addr)] == $past(fi.ack) &&
      s.link[$past(s.poll_addr)] == $past(poll_link))
      else $error("poll result not recorded in responder or carrier map");
   chk_poll_advance: assert property (poll_end |=>
      s.poll_addr == 5'($past(s.poll_addr) + 5'h01))
      else $error("poll address did not advance");
   chk_watch_event: assert property (watch_flip |=> s.sc_raw ##0 s.irq)
      else $error("watched link change did not raise the state change event");
   chk_op_done: assert property (op0_end |=> !s.op[0].launch && s.od_raw[0])
      else $error("user operation completion not reported");
   chk_read_result: assert property (op0_end and !s.op[0].wr |=>
      s.op[0].ack == $past(fi.ack) && s.op[0].data == $past(fi.rdata) &&
      s.alive[$past(s.op[0].phy)] == $past(fi.ack))
      else $error("read result, acknowledge or responder bit wrong");
   chk_round_robin: assert property (s.st == mpl_pkg::ST_PICK && s.enable &&
      s.op[0].launch && s.op[1].launch |=>
      s.src == ($past(s.rr_last) ? mpl_pkg::SRC_OP0 : mpl_pkg::SRC_OP1))
      else $error("pending operations not served in turn");
   chk_user_first: assert property (s.st == mpl_pkg::ST_PICK && s.enable &&
      (s.op[0].launch || s.op[1].launch) |=> s.src != mpl_pkg::SRC_POLL ##0 s.start)
      else $error("poll frame started while a user operation waits");
   chk_done_irq: assert property ((s.od_raw & s.od_mask) != 2'b00 |-> s.irq)
      else $error("enabled completion without interrupt");
endmodule

// ---- dv/mpl_phy_model.sv ----
// behavioural management bus responder standing for several phy chips
`timescale 1ns/1ps
module mpl_phy_model
(
   input wire logic mdc_i,
   input wire logic mdio_i,
   input wire logic host_oe_i,
   input wire logic [31:0] present_i,
   input wire logic [31:0] link_i,
   output logic drv_oe_o,
   output logic drv_val_o,
   output logic [25:0] last_wr_o,
   output int pre_o
);
   int n = 0;
   int ones = 0;
   logic [13:0] hdr;
   logic [15:0] sh;
   logic [15:0] mem [0:31];
   initial
   begin
      drv_oe_o = 1'b0;
      drv_val_o = 1'b1;
      last_wr_o = '0;
      pre_o = 0;
      foreach (mem[i]) mem[i] = 16'h0000;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // frame parse on the rising clock: ones, start, op, phy, reg, turnaround, data
   always @(posedge mdc_i)
   begin
      if (n == 0)
      begin
         if (host_oe_i && !mdio_i)
         begin
            n = 1;
            hdr = '0;
            pre_o = ones;
            ones = 0;
         end
         else if (host_oe_i)
            ones = ones + 1;
      end
      else
      begin
         if (n < 14)
            hdr = {hdr[12:0], mdio_i};
         if (n == 13)
            sh = (hdr[4:0] == 5'h01) ? {13'h0, link_i[hdr[9:5]], 2'h0} : mem[hdr[4:0]];
         if (n >= 16 && hdr[11:10] == 2'b01)
            sh = {sh[14:0], mdio_i};
         if (n == 31 && hdr[11:10] == 2'b01)
         begin
            mem[hdr[4:0]] = sh;
            last_wr_o = {hdr[9:0], sh};
         end
         n = (n == 31) ? 0 : n + 1;
      end
   end
   // answer changes after the falling clock, so it is settled long before the rise;
   // first turnaround bit is left to the pull-up, the second is driven low
   always @(negedge mdc_i)
   begin
      drv_oe_o = (n >= 15) && (hdr[11:10] == 2'b10) && present_i[hdr[9:5]];
      drv_val_o = (n == 15) ? 1'b0 : sh[(31 - n) & 15];
   end
endmodule

// ---- dv/tb_mpl_phy_poller.sv ----
// bench: register access, poll maps, watched phy, user operations, frames
`timescale 1ns/1ps
`include "mpl_consts.svh"
module tb_mpl_phy_poller;
   logic clock_i = 1'b0;
   logic rst_i = 1'b1;
   logic [7:0] avs_address_i = 8'h00;
   logic avs_read_i = 1'b0;
   logic avs_write_i = 1'b0;
   logic [31:0] avs_writedata_i = 32'h0;
   logic [31:0] avs_readdata_o, rd;
   logic avs_waitrequest_o, irq_o, mdc, mdo, mdoe, phy_oe, phy_val;
   logic [31:0] present = 32'h00000015;
   logic [31:0] link = 32'h00000005;
   logic [25:0] last_wr;
   int pre_cnt;
   int miscompares = 0;
   int num_checks = 0;
   int mdc_rises = 0;
   // wire has a pull-up: released line reads one
   wire mdio = mdoe ? mdo : (phy_oe ? phy_val : 1'b1);
   initial forever #2.5 clock_i = ~clock_i;
   always @(posedge mdc) mdc_rises++;
   mpl_phy_poller mpl_phy_poller_inst (.clock_i(clock_i), .rst_i(rst_i),
      .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
      .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hF),
      .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
      .irq_o(irq_o), .management_clock_pin_o(mdc), .mgmt_data_i(mdio),
      .mgmt_data_o(mdo), .mgmt_data_oe_o(mdoe));
   mpl_phy_model mpl_phy_model_inst (.mdc_i(mdc), .mdio_i(mdio), .host_oe_i(mdoe),
      .present_i(present), .link_i(link), .drv_oe_o(phy_oe), .drv_val_o(phy_val),
      .last_wr_o(last_wr), .pre_o(pre_cnt));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // one access, held until waitrequest low meets a rising edge
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_write_i <= wr;
      avs_read_i <= !wr;
      // sampled at the rising edge, before the design's registers move
      do
      begin
         @(posedge clock_i);
         k++;
      end
      while (avs_waitrequest_o !== 1'b0 && k < 50);
      rd = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
      // one idle edge so the next request is not assigned in the same step
      @(posedge clock_i);
      if (k >= 50)
      begin
         miscompares++;
         summarize();
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   // bounded polling of a register until the masked value appears
   task automatic wait_for(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
      int k;
      k = 0;
      do
      begin
         bus(1'b0, a, 32'h0);
         k++;
      end
      while ((rd & m) !== v && k < 12000);
      if (k >= 12000)
      begin
         miscompares++;
         summarize();
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      repeat (10) @(posedge clock_i);
      rst_i <= 1'b0;
      @(posedge clock_i);
      rchk(`MPL_OFF_CTRL, 32'h00010063);
      rchk(8'hFC, 32'h0);
      bus(1'b1, `MPL_OFF_WATCH, 32'h00000042);
      bus(1'b1, `MPL_OFF_OD_MSET, 32'h1);
      bus(1'b1, `MPL_OFF_CTRL, 32'h00000007);
      chk(mdc_rises, 0);
      bus(1'b1, `MPL_OFF_CTRL, 32'h40000007);
      wait_for(`MPL_OFF_ALIVE, 32'hFFFFFFFF, 32'h15);
      rchk(`MPL_OFF_LINK, 32'h5);
      rchk(`MPL_OFF_SC_RAW, 32'h1);
      rchk(`MPL_OFF_SC_MSK, 32'h1);
      chk(irq_o, 1'b1);
      rchk(`MPL_OFF_WATCH, 32'hC2);
      // watched phy loses link after the event is cleared
      bus(1'b1, `MPL_OFF_SC_RAW, 32'h1);
      link <= 32'h1;
      wait_for(`MPL_OFF_SC_RAW, 32'h1, 32'h1);
      rchk(`MPL_OFF_WATCH, 32'h42);
      bus(1'b1, `MPL_OFF_SC_RAW, 32'h1);
      // write on op1 and read on op0 queued together: op1 goes first
      bus(1'b1, `MPL_OFF_OP1, 32'hC0A4A5C3);
      bus(1'b1, `MPL_OFF_OP0, 32'h80A40000);
      wait_for(`MPL_OFF_OP0, 32'h80000000, 32'h0);
      rchk(`MPL_OFF_OP0, 32'h20A4A5C3);
      rchk(`MPL_OFF_OP1, 32'h40A4A5C3);
      chk({6'h0, last_wr}, {6'h0, 5'h4, 5'h5, 16'hA5C3});
      chk(pre_cnt, 0);
      rchk(`MPL_OFF_OD_RAW, 32'h3);
      rchk(`MPL_OFF_OD_MSK, 32'h1);
      chk(irq_o, 1'b1);
      // read of a phy that has gone away
      present <= 32'h5;
      bus(1'b1, `MPL_OFF_OP0, 32'h80A40000);
      wait_for(`MPL_OFF_OP0, 32'h80000000, 32'h0);
      chk(rd & 32'hE0000000, 32'h0);
      rchk(`MPL_OFF_ALIVE, 32'h5);
      // preamble back on
      bus(1'b1, `MPL_OFF_CTRL, 32'h40010007);
      bus(1'b1, `MPL_OFF_OP1, 32'hC0A41234);
      wait_for(`MPL_OFF_OP1, 32'h80000000, 32'h0);
      chk(pre_cnt, 32);
      chk({6'h0, last_wr}, {6'h0, 5'h4, 5'h5, 16'h1234});
      bus(1'b1, `MPL_OFF_OD_RAW, 32'h3);
      bus(1'b1, `MPL_OFF_OD_MCLR, 32'h1);
      rchk(`MPL_OFF_OD_MSK, 32'h0);
      rchk(`MPL_OFF_OD_MSET, 32'h0);
      chk(irq_o, 1'b0);
      summarize();
   end
endmodule
